// *** shared/sram_write_defs.svh ***
/*
 * Constants of the byte-write decode block: lane layout, reset values and timing.
 * Assumes a 25 MHz clock; included by bare name.
 */
`ifndef SRAM_WRITE_DEFS_SVH
`define SRAM_WRITE_DEFS_SVH

`define LANES 4
`define LANE_BITS 9
`define LANE_DATA_BITS 8
`define LANE_PARITY_POS 8
`define WORD_BITS 36
`define ADDR_BITS 4
`define MEM_WORDS 16
`define CLK_PERIOD_NS 40
`define POWER_WAIT_MS 1
`define POWER_WAIT_CYCLES ((`POWER_WAIT_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEEP_CYCLES 2
`define CYCLE_IDLE_RESET 4'h1

`endif

// *** shared/sram_write_pkg.sv ***
/*
 * Types of the byte-write decode block.
 * Assumes sram_write_defs.svh is on the include path.
 */
`default_nettype none
`include "sram_write_defs.svh"
package sram_write_pkg;
	// one-hot cycle kind held for the data bus drive decision
	typedef enum logic [3:0] {
		CYC_IDLE = 4'h1,
		CYC_READ = 4'h2,
		CYC_WRITE = 4'h4,
		CYC_SLEEP = 4'h8
	} cycle_t;
endpackage
`default_nettype wire

// *** hw/sync_sram_byte_write_decode.sv ***
/*
 * Write-control decode, lane-masked storage and data-bus drive control of a
 * four-lane synchronous SRAM with parity per lane.
 * Assumes the host meets setup and hold, deselects before sleep and waits
 * out power-up; the bench resolves the data bus from the enables.
 */
// Operation
// RULE1: global write low, or gate low with all selects low, writes all four lanes.
// RULE2: gate low with global write high writes exactly the lanes selected low.
// RULE3: a lane write updates eight data bits and parity; other lanes keep contents.
// RULE4: data pins driven from cycle type and asynchronous output enable, never sampled.
// RULE5: after a write, outputs stay off until a strobe starts a new read.
// RULE6: host deselects the device before asserting sleep request.
// RULE7: on leaving sleep the data pins are held in high impedance.
// RULE8: host waits at least 1 ms after power-up before any access.
// RULE9: write when global write low or gate low with a selected lane; else read.
// RULE10: processor strobe always begins a read regardless of write inputs; the code begins none while asleep.
// RULE11: during writes the output enable is masked so pins stay off.
// RULE12: write controls are sampled with the data on one edge for one word.
`default_nettype none
`include "sram_write_defs.svh"
module sync_sram_byte_write_decode
	import sram_write_pkg::*;
#(
	parameter int POWER_WAIT = `POWER_WAIT_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// access control
	input wire logic chip_select_n,
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic [`ADDR_BITS-1:0] addr,
	// write control
	input wire logic global_write_n,
	input wire logic byte_write_gate_n,
	input wire logic [`LANES-1:0] lane_write_select_n,
	// data bus, lane i at bits 9i+8..9i, parity at the top of each lane
	input wire logic [`WORD_BITS-1:0] data_in,
	output logic [`WORD_BITS-1:0] data_out,
	output logic data_oe_n,
	// asynchronous pins
	input wire logic output_enable_n,
	input wire logic sleep_request,
	// status
	output logic power_ready,
	output logic asleep
);
	localparam int POWER_CNT_BITS = $clog2(`POWER_WAIT_CYCLES + 1);
	cycle_t cycle_reg;
	cycle_t cycle_next;
	logic [`ADDR_BITS-1:0] addr_reg;
	logic [`WORD_BITS-1:0] data_out_reg;
	logic [2:0] sleep_sync_reg;
	logic sleep_state_reg;
	logic [1:0] sleep_cnt_reg;
	logic [POWER_CNT_BITS-1:0] power_cnt_reg;

	// RULE9 write detect
	wire any_lane = ~&lane_write_select_n;
	wire is_write = ~global_write_n | (~byte_write_gate_n & any_lane);
	wire full_write = ~global_write_n | (~byte_write_gate_n & ~|lane_write_select_n);
	// RULE10 processor strobe forces read
	wire proc_start = ~processor_addr_strobe_n & ~chip_select_n;
	wire ctrl_start = processor_addr_strobe_n & ~controller_addr_strobe_n & ~chip_select_n;
	wire start = proc_start | ctrl_start;
	wire no_strobe = processor_addr_strobe_n & controller_addr_strobe_n;
	wire deselect = chip_select_n & ~no_strobe;
	// a strobeless write only continues an access already open
	wire in_access = (cycle_reg == CYC_READ) | (cycle_reg == CYC_WRITE);
	wire do_write = is_write & ~asleep & (ctrl_start | (no_strobe & in_access));
	// RULE1 full word write
	// RULE2 per-lane selection
	wire [`LANES-1:0] lane_en = full_write ? {`LANES{1'b1}} : ~lane_write_select_n;
	wire [`LANES-1:0] lane_we = {`LANES{do_write}} & lane_en;
	wire [`ADDR_BITS-1:0] wr_addr = ctrl_start ? addr : addr_reg;
	// read sees the word as it stood before this edge's write
	wire [`ADDR_BITS-1:0] rd_addr = start ? addr : addr_reg;
	wire [`WORD_BITS-1:0] rd_word;

	// RULE12 one edge, one word
	// RULE3 masked lane update with parity
	genvar g;
	generate
		for (g = 0; g < `LANES; g++) begin : lane
			// one array per lane keeps each array to a single writer
			logic [`LANE_BITS-1:0] lane_mem [`MEM_WORDS];
			always_ff @(posedge clk) begin
				if (lane_we[g])
					lane_mem[wr_addr] <= data_in[g*`LANE_BITS +: `LANE_BITS];
			end
			assign rd_word[g*`LANE_BITS +: `LANE_BITS] = lane_mem[rd_addr];
		end
	endgenerate

	// RULE5 reads only start on a strobe
	always_comb begin
		cycle_next = cycle_reg;
		if (asleep)
			cycle_next = CYC_SLEEP;
		else if (do_write)
			cycle_next = CYC_WRITE;
		else if (start)
			cycle_next = CYC_READ;
		else if (cycle_reg == CYC_SLEEP)
			cycle_next = CYC_IDLE;
		else if (deselect)
			cycle_next = CYC_IDLE;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cycle_reg <= CYC_IDLE;
			addr_reg <= '0;
			data_out_reg <= '0;
		end else begin
			cycle_reg <= cycle_next;
			if (start)
				addr_reg <= addr;
			data_out_reg <= rd_word;
		end
	end

	// sleep pin: three stages, change counts when last two agree
	always_ff @(posedge clk) begin
		if (rst)
			sleep_sync_reg <= '0;
		else
			sleep_sync_reg <= {sleep_sync_reg[1:0], sleep_request};
	end
	wire sleep_seen = sleep_sync_reg[2] & sleep_sync_reg[1];
	wire wake_seen = ~sleep_sync_reg[2] & ~sleep_sync_reg[1];

	// two cycles to enter or leave, as the part allows
	always_ff @(posedge clk) begin
		if (rst) begin
			sleep_state_reg <= 1'b0;
			sleep_cnt_reg <= '0;
		end else if ((sleep_seen && !sleep_state_reg) || (wake_seen && sleep_state_reg)) begin
			if (sleep_cnt_reg == 2'(`SLEEP_CYCLES - 1)) begin
				sleep_state_reg <= ~sleep_state_reg;
				sleep_cnt_reg <= '0;
			end else
				sleep_cnt_reg <= sleep_cnt_reg + 2'h1;
		end else
			sleep_cnt_reg <= '0;
	end
	assign asleep = sleep_state_reg;

	// power-up wait is only reported; the host is expected to honour it
	always_ff @(posedge clk) begin
		if (rst)
			power_cnt_reg <= '0;
		else if (power_cnt_reg != POWER_CNT_BITS'(POWER_WAIT))
			power_cnt_reg <= power_cnt_reg + POWER_CNT_BITS'(1);
	end
	assign power_ready = power_cnt_reg == POWER_CNT_BITS'(POWER_WAIT);

	// RULE4 asynchronous enable gating
	// RULE11 enable masked in writes
	// RULE7 off while asleep and on exit
	wire drive = (cycle_reg == CYC_READ) & ~output_enable_n & ~do_write;
	assign data_oe_n = ~drive;
	assign data_out = data_out_reg;

	// bus drive checks
	a_write_masks_oe: assert property (@(posedge clk) disable iff (rst) // RULE11
		do_write |-> data_oe_n)
		else $error("bus driven during write");
	a_oe_async: assert property (@(posedge clk) disable iff (rst) // RULE4
		output_enable_n |-> data_oe_n)
		else $error("bus driven with enable high");
	a_after_write_off: assert property (@(posedge clk) disable iff (rst) // RULE5
		(cycle_reg == CYC_WRITE && !start && !do_write) |=> data_oe_n)
		else $error("bus driven after write without strobe");
	a_deselect_off: assert property (@(posedge clk) disable iff (rst) // RULE4
		deselect |=> data_oe_n)
		else $error("bus driven after deselect");
	a_sleep_exit_off: assert property (@(posedge clk) disable iff (rst) // RULE7
		$fell(asleep) |-> data_oe_n [*2])
		else $error("bus driven leaving sleep");

	// start and decode checks
	a_proc_read: assert property (@(posedge clk) disable iff (rst) // RULE10
		(proc_start && !asleep) |=> cycle_reg == CYC_READ)
		else $error("strobe did not start read");
	a_proc_no_write: assert property (@(posedge clk) disable iff (rst) // RULE10
		proc_start |-> !do_write)
		else $error("write taken with processor strobe");
	a_read_after_write: assert property (@(posedge clk) disable iff (rst) // RULE5
		(cycle_reg == CYC_WRITE && start && !do_write && !asleep) |=> cycle_reg == CYC_READ)
		else $error("strobe after write did not reopen read");
	a_write_detect: assert property (@(posedge clk) disable iff (rst) // RULE9
		(global_write_n && byte_write_gate_n) |-> !do_write)
		else $error("write without write inputs");
	a_ctrl_write: assert property (@(posedge clk) disable iff (rst) // RULE9
		(ctrl_start && is_write && !asleep) |-> do_write)
		else $error("controller write not taken");

	// storage checks
	a_global_full: assert property (@(posedge clk) disable iff (rst) // RULE1
		(do_write && (!global_write_n || (!byte_write_gate_n && lane_write_select_n == 4'h0)))
		|-> lane_en == 4'hF)
		else $error("full write lost lanes");
	a_global_all: assert property (@(posedge clk) disable iff (rst) // RULE1
		(do_write && !global_write_n)
		|=> lane[3].lane_mem[$past(wr_addr)] == $past(data_in[35:27]))
		else $error("global write missed top lane");
	a_lane_select: assert property (@(posedge clk) disable iff (rst) // RULE2
		(global_write_n && !byte_write_gate_n && any_lane) |-> lane_en == ~lane_write_select_n)
		else $error("lane enables differ from selects");
	a_lane_keep: assert property (@(posedge clk) disable iff (rst) // RULE3
		(do_write && !lane_en[0])
		|=> lane[0].lane_mem[$past(wr_addr)] == $past(lane[0].lane_mem[wr_addr]))
		else $error("unselected lane changed");
	a_parity_lane: assert property (@(posedge clk) disable iff (rst) // RULE3
		(do_write && lane_en[1])
		|=> lane[1].lane_mem[$past(wr_addr)][8] == $past(data_in[17]))
		else $error("lane parity not written");
	a_sample_edge: assert property (@(posedge clk) disable iff (rst) // RULE12
		(do_write && lane_en[0])
		|=> lane[0].lane_mem[$past(wr_addr)] == $past(data_in[8:0]))
		else $error("write not taken on its edge");
endmodule
`default_nettype wire

// *** verif/host_bus_model.sv ***
/* host model that drives every bus input of the byte-write block.
   assumes one clock and that the bench calls its tasks in order. */
`default_nettype none
`include "sram_write_defs.svh"
module host_bus_model (
	// clock
	input wire logic clk,
	// bus drive
	output var logic chip_select_n,
	output var logic processor_addr_strobe_n,
	output var logic controller_addr_strobe_n,
	output var logic [`ADDR_BITS-1:0] addr,
	output var logic global_write_n,
	output var logic byte_write_gate_n,
	output var logic [`LANES-1:0] lane_write_select_n,
	output var logic [`WORD_BITS-1:0] data_in,
	// asynchronous pins
	output var logic output_enable_n,
	output var logic sleep_request
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{chip_select_n, processor_addr_strobe_n, controller_addr_strobe_n} = 3'h7;
		{global_write_n, byte_write_gate_n, lane_write_select_n} = 6'h3F;
		addr = 4'h0;
		data_in = 36'h0;
		output_enable_n = 1'h0;
		sleep_request = 1'h0;
	end
	// s is {select, cpu strobe, ctrl strobe}, w is {global, gate, lanes}
	task automatic cyc(input logic [2:0] s, input logic [5:0] w, input logic [3:0] a,
		input logic [35:0] d);
		@(posedge clk);
		{chip_select_n, processor_addr_strobe_n, controller_addr_strobe_n} <= s;
		{global_write_n, byte_write_gate_n, lane_write_select_n} <= w;
		addr <= a;
		data_in <= d;
	endtask
	task automatic nap(input logic z);
		cyc(3'h5, 6'h3F, 4'h0, 36'h0);
		@(posedge clk);
		sleep_request <= z;
	endtask
	task automatic oe(input logic v);
		output_enable_n <= v;
	endtask
endmodule
`default_nettype wire

// *** verif/tb_sync_sram_byte_write_decode.sv ***
/* self-checking bench of the byte-write decode block.
   assumes host_bus_model drives all bus inputs. */
`default_nettype none
`define CHK(n, e, g) tests_run++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("BAD %s exp %h got %h", n, e, g); \
	end
module tb_sync_sram_byte_write_decode;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic chip_select_n, processor_addr_strobe_n, controller_addr_strobe_n;
	logic global_write_n, byte_write_gate_n, output_enable_n, sleep_request;
	logic data_oe_n, power_ready, asleep;
	logic [3:0] addr, lane_write_select_n;
	logic [35:0] data_in, data_out;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	always #20 clk = ~clk;
	sync_sram_byte_write_decode #(.POWER_WAIT(8)) dut_u (.*);
	host_bus_model host_u (.*);
	task automatic rd(input logic [3:0] a, input logic [35:0] e);
		host_u.cyc(3'h1, 6'h3F, a, 36'h0);
		repeat (2) host_u.cyc(3'h7, 6'h3F, a, 36'h0);
		#1;
		`CHK("read word", e, data_out)
		`CHK("read drive", 1'h0, data_oe_n)
	endtask
	task automatic wr(input logic [5:0] w, input logic [3:0] a, input logic [35:0] d);
		host_u.cyc(3'h2, w, a, d);
		host_u.cyc(3'h7, 6'h3F, a, ~d);
		#1;
		`CHK("drive off", 1'h1, data_oe_n)
	endtask
	task automatic t_write();
		wr(6'h1F, 4'h1, 36'hAAAAAAAAA);
		rd(4'h1, 36'hAAAAAAAAA);
		wr(6'h20, 4'h1, 36'h555555555);
		rd(4'h1, 36'h555555555);
		wr(6'h25, 4'h1, 36'hFFFFFFFFF);
		rd(4'h1, 36'h555555555 | 36'hFF803FE00);
		host_u.cyc(3'h2, 6'h2F, 4'h1, 36'h0);
		rd(4'h1, 36'h555555555 | 36'hFF803FE00);
		$display("done write");
	endtask
	task automatic t_oe();
		@(posedge clk);
		host_u.oe(1'h1);
		#1;
		`CHK("oe high", 1'h1, data_oe_n)
		host_u.oe(1'h0);
		#1;
		`CHK("oe low", 1'h0, data_oe_n)
		$display("done oe");
	endtask
	task automatic t_ps();
		wr(6'h1F, 4'h2, 36'h0);
		host_u.cyc(3'h1, 6'h00, 4'h2, 36'h123456789);
		rd(4'h2, 36'h0);
		$display("done strobe");
	endtask
	task automatic t_sleep();
		host_u.nap(1'h1);
		repeat (8) @(posedge clk);
		#1;
		`CHK("asleep", 1'h1, asleep)
		host_u.nap(1'h0);
		repeat (8) @(posedge clk);
		#1;
		`CHK("awake", 1'h0, asleep)
		`CHK("wake drive", 1'h1, data_oe_n)
		rd(4'h1, 36'h555555555 | 36'hFF803FE00);
		$display("done sleep");
	endtask
	task automatic print_verdict();
		$display("checks %0d bad %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		repeat (20) @(posedge clk);
		#1;
		`CHK("power ready", 1'h1, power_ready)
		t_write();
		t_oe();
		t_ps();
		t_sleep();
		print_verdict();
	end
	// hang guard well above the fewer than a hundred cycles used
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			print_verdict();
		end
	end
endmodule
`default_nettype wire
